// >>> design/t2ccr_top.sv
// Timer 2 control logic: control register, 16-bit counter, capture/reload register, baud ticks.
// Assumes an Avalon-MM master on the system clock and pins already synchronous to clk_in.
`timescale 1ns/1ps

module t2ccr_top #(
	parameter int CNT_W = t2ccr_pkg::CNT_W
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [t2ccr_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [t2ccr_pkg::DATA_W-1:0] avs_writedata_in,
	output logic [t2ccr_pkg::DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic ext_trigger_pin_in,
	input wire logic ext_count_pin_in,
	input wire logic timer1_overflow_in,
	output logic rx_baud_tick_out,
	output logic tx_baud_tick_out,
	output logic irq_out
);
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
		$error("CNT_W must lie between 2 and 16.");
	end

	t2ccr_pkg::t2ccr_ctl_t ctl;
	t2ccr_pkg::t2ccr_req_t req;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] cap_reload;
	logic [1:0] irq_mask;
	logic trig_q;
	logic cnt_pin_q;
	logic trig_fall;
	logic cnt_fall;
	logic baud_mode;
	logic reload_mode;
	logic count_step;
	logic overflow;
	logic trig_event;
	logic access;
	logic wr_ctl;
	logic wr_count;
	logic wr_cap;
	logic wr_stat;
	logic wr_mask;
	logic clr_ovf;
	logic clr_ext;
	logic [1:0] flags;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] next_cap;
	logic [t2ccr_pkg::DATA_W-1:0] rd_mux;

	function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
		input logic [t2ccr_pkg::DATA_W-1:0] wd, input logic [3:0] be);
		logic [15:0] wide;
		wide = 16'(old);
		if (be[0]) begin
			wide[7:0] = wd[7:0];
		end
		if (be[1]) begin
			wide[15:8] = wd[15:8];
		end
		return wide[CNT_W-1:0];
	endfunction

	assign req = '{read: avs_read_in, write: avs_write_in, address: avs_address_in,
		byteenable: avs_byteenable_in, writedata: avs_writedata_in};

	// Every access takes exactly one wait cycle, so read data can come from a flop.
	assign access = (req.read || req.write) && !avs_waitrequest_out;
	assign wr_ctl = access && req.write && req.address == t2ccr_pkg::OFF_CONTROL
		&& req.byteenable[0];
	assign wr_count = access && req.write && req.address == t2ccr_pkg::OFF_COUNT;
	assign wr_cap = access && req.write && req.address == t2ccr_pkg::OFF_CAPRELOAD;
	assign wr_stat = access && req.write && req.address == t2ccr_pkg::OFF_IRQ_STATUS
		&& req.byteenable[0];
	assign wr_mask = access && req.write && req.address == t2ccr_pkg::OFF_IRQ_MASK
		&& req.byteenable[0];

	// Flags clear by writing zero in the control byte or one in the status word.
	assign clr_ovf = (wr_ctl && !req.writedata[t2ccr_pkg::BIT_OVERFLOW_FLAG])
		|| (wr_stat && req.writedata[t2ccr_pkg::IRQ_BIT_OVERFLOW]);
	assign clr_ext = (wr_ctl && !req.writedata[t2ccr_pkg::BIT_EXT_EVENT_FLAG])
		|| (wr_stat && req.writedata[t2ccr_pkg::IRQ_BIT_EXT_EVENT]);
	assign flags = {ctl.external_event_flag, ctl.overflow_flag};

	assign trig_fall = trig_q && !ext_trigger_pin_in;
	assign cnt_fall = cnt_pin_q && !ext_count_pin_in;
	assign baud_mode = ctl.rx_baud_source_sel || ctl.tx_baud_source_sel;
	assign reload_mode = !ctl.capture_reload_sel || baud_mode;
	assign count_step = ctl.run_control && (ctl.count_source_sel ? cnt_fall : 1'b1);
	assign overflow = count_step && (count == {CNT_W{1'b1}});
	assign trig_event = ctl.trigger_pin_enable && !baud_mode && trig_fall;

	always_comb begin
		next_count = count;
		if (wr_count) begin
			next_count = merge16(count, req.writedata, req.byteenable);
		end else if (trig_event && reload_mode) begin
			next_count = cap_reload;
		end else if (overflow) begin
			next_count = reload_mode ? cap_reload : '0;
		end else if (count_step) begin
			next_count = count + 1'b1;
		end
	end

	// A capture beats a software write in the same cycle so the event is not lost.
	always_comb begin
		next_cap = cap_reload;
		if (trig_event && !reload_mode) begin
			next_cap = count;
		end else if (wr_cap) begin
			next_cap = merge16(cap_reload, req.writedata, req.byteenable);
		end
	end

	always_comb begin
		rd_mux = '0;
		case (req.address)
			t2ccr_pkg::OFF_CONTROL: rd_mux = 32'(ctl);
			t2ccr_pkg::OFF_COUNT: rd_mux = 32'(count);
			t2ccr_pkg::OFF_CAPRELOAD: rd_mux = 32'(cap_reload);
			t2ccr_pkg::OFF_IRQ_STATUS: rd_mux = 32'(flags);
			t2ccr_pkg::OFF_IRQ_MASK: rd_mux = 32'(irq_mask);
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= '0;
		end else begin
			avs_waitrequest_out <= !((req.read || req.write) && avs_waitrequest_out);
			if (req.read && avs_waitrequest_out) begin
				avs_readdata_out <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			trig_q <= 1'b1;
			cnt_pin_q <= 1'b1;
		end else begin
			trig_q <= ext_trigger_pin_in;
			cnt_pin_q <= ext_count_pin_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctl <= t2ccr_pkg::CONTROL_RESET;
		end else begin
			if (wr_ctl) begin
				// Run control is plain software state; mode writes leave it to software.
				ctl.rx_baud_source_sel <= req.writedata[t2ccr_pkg::BIT_RX_BAUD_SEL];
				ctl.tx_baud_source_sel <= req.writedata[t2ccr_pkg::BIT_TX_BAUD_SEL];
				ctl.trigger_pin_enable <= req.writedata[t2ccr_pkg::BIT_TRIGGER_EN];
				ctl.run_control <= req.writedata[t2ccr_pkg::BIT_RUN_CONTROL];
				ctl.count_source_sel <= req.writedata[t2ccr_pkg::BIT_COUNT_SRC];
				ctl.capture_reload_sel <= req.writedata[t2ccr_pkg::BIT_CAP_RELOAD];
			end
			// Set wins over a clear in the same cycle; nothing else ever clears a flag.
			ctl.overflow_flag <= (overflow && !baud_mode)
				|| (ctl.overflow_flag && !clr_ovf);
			ctl.external_event_flag <= trig_event
				|| (ctl.external_event_flag && !clr_ext);
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			count <= t2ccr_pkg::COUNT_RESET[CNT_W-1:0];
			cap_reload <= t2ccr_pkg::COUNT_RESET[CNT_W-1:0];
		end else begin
			count <= next_count;
			cap_reload <= next_cap;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_mask <= t2ccr_pkg::IRQ_MASK_RESET;
			irq_out <= 1'b0;
		end else begin
			if (wr_mask) begin
				irq_mask <= req.writedata[1:0];
			end
			irq_out <= |(flags & irq_mask);
		end
	end

	// Baud ticks are one-cycle pulses, delayed by one flop from the overflow that makes them.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rx_baud_tick_out <= 1'b0;
			tx_baud_tick_out <= 1'b0;
		end else begin
			rx_baud_tick_out <= ctl.rx_baud_source_sel ? overflow : timer1_overflow_in;
			tx_baud_tick_out <= ctl.tx_baud_source_sel ? overflow : timer1_overflow_in;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// Shared steps; each names one situation that one or more properties start from.
	sequence trig_fall_s;
		ext_trigger_pin_in ##1 (!ext_trigger_pin_in && ctl.trigger_pin_enable && !baud_mode);
	endsequence

	sequence quiet_ctl_s;
		!wr_ctl && !wr_stat;
	endsequence

	sequence bus_req_s;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence

	sequence edge_reload_s;
		ext_trigger_pin_in ##1 (!ext_trigger_pin_in && ctl.trigger_pin_enable && !baud_mode
			&& reload_mode && !wr_count);
	endsequence

	sequence edge_capture_s;
		ext_trigger_pin_in ##1 (!ext_trigger_pin_in && ctl.trigger_pin_enable && !baud_mode
			&& !reload_mode);
	endsequence

	sequence ovf_set_s;
		overflow && !baud_mode;
	endsequence

	// One wait state per access, then idle again, so a master never sees a stale answer.
	wait_answer_a: assert property (bus_req_s |=> !avs_waitrequest_out)
		else $error("Bus request got no answer.");
	wait_single_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("Wait request stayed low.");
	rd_data_hold_a: assert property (!(avs_read_in && avs_waitrequest_out)
		|=> $stable(avs_readdata_out))
		else $error("Read data moved without a read.");

	ovf_flag_set_a: assert property (ovf_set_s |=> ctl.overflow_flag)
		else $error("Overflow did not set the overflow flag.");
	ovf_flag_hold_a: assert property (ctl.overflow_flag ##0 quiet_ctl_s
		|=> ctl.overflow_flag)
		else $error("Overflow flag dropped without software.");
	ovf_flag_clear_a: assert property (clr_ovf && !(overflow && !baud_mode)
		|=> !ctl.overflow_flag)
		else $error("Software clear left the overflow flag set.");
	ovf_set_wins_a: assert property (ovf_set_s ##0 clr_ovf
		|=> ctl.overflow_flag)
		else $error("Overflow lost to a clear in the same cycle.");
	baud_no_flag_a: assert property (!ctl.overflow_flag && baud_mode
		|=> !ctl.overflow_flag)
		else $error("Overflow flag set in baud mode.");
	ext_flag_edge_a: assert property (trig_fall_s |=> ctl.external_event_flag)
		else $error("Trigger edge did not set the external flag.");
	ext_set_wins_a: assert property (trig_fall_s ##0 clr_ext
		|=> ctl.external_event_flag)
		else $error("Trigger edge lost to a clear in the same cycle.");
	ext_flag_hold_a: assert property (ctl.external_event_flag ##0 quiet_ctl_s
		|=> ctl.external_event_flag)
		else $error("External flag dropped without software.");
	ext_flag_clear_a: assert property (clr_ext && !trig_event
		|=> !ctl.external_event_flag)
		else $error("Software clear left the external flag set.");

	irq_request_a: assert property (((flags & irq_mask) != 2'h0 && !wr_mask)
		##0 quiet_ctl_s |=> irq_out ##1 irq_out)
		else $error("Enabled flag gave no interrupt.");
	irq_quiet_a: assert property ((flags & irq_mask) == 2'h0 |=> !irq_out)
		else $error("Interrupt raised with no enabled flag.");

	rx_baud_src_a: assert property (##1 rx_baud_tick_out
		== ($past(ctl.rx_baud_source_sel) ? $past(overflow) : $past(timer1_overflow_in)))
		else $error("Receive baud tick from wrong source.");
	tx_baud_src_a: assert property (##1 tx_baud_tick_out
		== ($past(ctl.tx_baud_source_sel) ? $past(overflow) : $past(timer1_overflow_in)))
		else $error("Transmit baud tick from wrong source.");

	trig_ignored_a: assert property (trig_fall && (!ctl.trigger_pin_enable || baud_mode)
		&& !ctl.external_event_flag |=> !ctl.external_event_flag)
		else $error("Ignored trigger edge set the external flag.");
	trig_no_capture_a: assert property (trig_fall && !trig_event && !wr_cap
		|=> cap_reload == $past(cap_reload))
		else $error("Ignored trigger edge changed the capture register.");
	capture_take_a: assert property (trig_event && !reload_mode
		|=> cap_reload == $past(count))
		else $error("Capture did not store the count.");
	edge_capture_a: assert property (edge_capture_s
		|=> cap_reload == $past(count))
		else $error("Trigger edge did not capture the count.");
	edge_reload_a: assert property (edge_reload_s
		|=> count == $past(cap_reload))
		else $error("Trigger edge did not reload the count.");
	reload_ovf_a: assert property (overflow && reload_mode && !wr_count
		|=> count == $past(cap_reload))
		else $error("Overflow did not reload the count.");
	baud_no_capture_a: assert property (baud_mode && !wr_cap
		|=> cap_reload == $past(cap_reload))
		else $error("Capture register changed in baud mode.");
	capture_wrap_a: assert property (overflow && !reload_mode && !wr_count
		|=> count == '0)
		else $error("Capture mode overflow did not wrap the count.");

	count_inc_a: assert property (ctl.run_control && !ctl.count_source_sel && !wr_count
		&& !trig_event && count != {CNT_W{1'b1}} |=> count == $past(count) + 1'b1)
		else $error("Internal clock did not advance the count.");
	pin_hold_a: assert property (ctl.count_source_sel && !cnt_fall && !wr_count
		&& !(trig_event && reload_mode) |=> count == $past(count))
		else $error("Count moved without a count pin edge.");
	pin_step_a: assert property (ctl.run_control && ctl.count_source_sel
		&& cnt_fall && !wr_count && !trig_event && count != {CNT_W{1'b1}}
		|=> count == $past(count) + 1'b1)
		else $error("Count pin edge did not advance the count.");
	run_stop_a: assert property (!ctl.run_control && !wr_count && !trig_event
		|=> count == $past(count))
		else $error("Count moved while stopped.");
endmodule // t2ccr_top

// >>> design/t2ccr_pkg.sv
// Constants, register map and field layout for the timer 2 control, capture and reload block.
// Assumes a 32-bit Avalon-MM register port with byte addresses and one aligned word per register.
package t2ccr_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_CAPRELOAD = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h10;
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_EXT_EVENT_FLAG = 6;
	localparam int BIT_RX_BAUD_SEL = 5;
	localparam int BIT_TX_BAUD_SEL = 4;
	localparam int BIT_TRIGGER_EN = 3;
	localparam int BIT_RUN_CONTROL = 2;
	localparam int BIT_COUNT_SRC = 1;
	localparam int BIT_CAP_RELOAD = 0;
	localparam int IRQ_BIT_OVERFLOW = 0;
	localparam int IRQ_BIT_EXT_EVENT = 1;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	// Bit order matches the control byte, most significant field first.
	typedef struct packed {
		logic overflow_flag;
		logic external_event_flag;
		logic rx_baud_source_sel;
		logic tx_baud_source_sel;
		logic trigger_pin_enable;
		logic run_control;
		logic count_source_sel;
		logic capture_reload_sel;
	} t2ccr_ctl_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [DATA_W-1:0] writedata;
	} t2ccr_req_t;
endpackage

// >>> testbench/t2ccr_pins_model.sv
// Pin-side model: trigger and count pins, plus the other timer's overflow pulses.
// Assumes the bench asks for pin levels; the model moves them only after a rising edge.
`timescale 1ns/1ps
module t2ccr_pins_model (
	input wire logic clk_in,
	input wire logic trig_lvl_in,
	input wire logic cnt_lvl_in,
	output logic ext_trigger_pin_out,
	output logic ext_count_pin_out,
	output logic timer1_overflow_out
);
	logic [2:0] div = 3'h0;
	initial ext_trigger_pin_out = 1'b1;
	initial ext_count_pin_out = 1'b1;
	initial timer1_overflow_out = 1'b0;
	// Levels are held for whole cycles so each edge shows as a one then a zero sample.
	always @(posedge clk_in) begin
		ext_trigger_pin_out <= trig_lvl_in;
		ext_count_pin_out <= cnt_lvl_in;
	end
	always @(posedge clk_in) begin
		div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
		timer1_overflow_out <= (div == 3'h4);
	end
endmodule // t2ccr_pins_model

// >>> testbench/t2ccr_top_test.sv
// Self-checking bench for the timer 2 control block over its register port.
// Assumes the pin model beside the block and one clock at 125 MHz.
`timescale 1ns/1ps
module t2ccr_top_test;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, trig = 1'b1, cnt = 1'b1, clr = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wd = 32'h0, rdata, q;
	logic wait_req, pin_t, pin_c, t1, rxt, txt, irq;
	int fail_count = 0, total_checks = 0, cyc = 0, rx_n, tx_n, t1_n;
	t2ccr_top dut (.clk_in(clk), .sys_rst_in(rst), .avs_read_in(rd), .avs_write_in(wr),
		.avs_address_in(addr), .avs_byteenable_in(4'hF), .avs_writedata_in(wd),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .ext_trigger_pin_in(pin_t),
		.ext_count_pin_in(pin_c), .timer1_overflow_in(t1), .rx_baud_tick_out(rxt),
		.tx_baud_tick_out(txt), .irq_out(irq));
	t2ccr_pins_model pins (.clk_in(clk), .trig_lvl_in(trig), .cnt_lvl_in(cnt),
		.ext_trigger_pin_out(pin_t), .ext_count_pin_out(pin_c), .timer1_overflow_out(t1));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		rx_n <= clr ? 0 : rx_n + (rxt === 1'b1);
		tx_n <= clr ? 0 : tx_n + (txt === 1'b1);
		t1_n <= clr ? 0 : t1_n + (t1 === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wd <= d;
		do @(posedge clk); while (wait_req !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic pin_edge(input logic on_count);
		@(posedge clk);
		if (on_count) cnt <= 1'b0;
		else trig <= 1'b0;
		repeat (2) @(posedge clk);
		cnt <= 1'b1;
		trig <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			access(0, 5'(4 * i), 0);
			check("reset value", q, 32'h0);
		end
		// External count source: the count moves only on falling edges of the count pin.
		access(1, 5'h04, 32'h0000);
		access(1, 5'h00, 32'h06);
		repeat (5) pin_edge(1);
		access(0, 5'h04, 0);
		check("count pin edges", q, 32'h5);
		// Reload mode with trigger enabled: an edge loads the reload value and sets the flag.
		access(1, 5'h08, 32'h1234);
		access(1, 5'h00, 32'h0E);
		pin_edge(0);
		access(0, 5'h04, 0);
		check("edge reload", q, 32'h1234);
		access(0, 5'h00, 0);
		check("ext flag", q, 32'h4E);
		repeat (20) @(posedge clk);
		access(1, 5'h10, 32'h2);
		repeat (3) @(posedge clk);
		check("ext irq", irq, 1'b1);
		access(1, 5'h0C, 32'h2);
		repeat (3) @(posedge clk);
		check("irq cleared", irq, 1'b0);
		// Capture mode: an edge copies the frozen count into the capture register.
		access(1, 5'h04, 32'h0077);
		access(1, 5'h00, 32'h0F);
		pin_edge(0);
		access(0, 5'h08, 0);
		check("capture", q, 32'h0077);
		access(1, 5'h00, 32'h07);
		pin_edge(0);
		access(0, 5'h00, 0);
		check("pin ignored", q, 32'h07);
		// Internal source, started by its own write, crossing FFFF into the reload value.
		access(1, 5'h04, 32'hFFF0);
		access(1, 5'h00, 32'h00);
		access(1, 5'h00, 32'h04);
		repeat (40) @(posedge clk);
		access(1, 5'h00, 32'h80);
		check("irq masked", irq, 1'b0);
		access(0, 5'h00, 0);
		check("overflow flag", q, 32'h80);
		access(0, 5'h04, 0);
		// 43 steps from FFF0: 16 reach the overflow and reload 0077, 27 more follow.
		check("reloaded", q, 32'h92);
		access(1, 5'h10, 32'h1);
		repeat (3) @(posedge clk);
		check("ovf irq", irq, 1'b1);
		access(1, 5'h0C, 32'h1);
		// Baud mode: ticks from this overflow, no overflow flag, trigger refused.
		access(1, 5'h04, 32'hFFF0);
		access(1, 5'h08, 32'hFFF0);
		clr <= 1'b1;
		access(1, 5'h00, 32'h3D);
		clr <= 1'b0;
		repeat (100) @(posedge clk);
		pin_edge(0);
		access(0, 5'h00, 0);
		check("baud no flags", q, 32'h3D);
		check("baud no irq", irq, 1'b0);
		check("rx ticks", rx_n > 3, 1'b1);
		check("tx ticks", tx_n, rx_n);
		access(0, 5'h04, 0);
		check("baud reload", q[15:4], 12'hFFF);
		access(1, 5'h00, 32'h00);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (50) @(posedge clk);
		check("rx from timer1", t1_n - rx_n <= 1, 1'b1);
		check("tx from timer1", t1_n - tx_n <= 1, 1'b1);
		give_verdict();
	end
endmodule // t2ccr_top_test
